// File: include/adc_pkg.sv
package adc_pkg;

    // Core clock.
    localparam int CLK_PERIOD_NS = 20;

    // Result word and buffering.
    localparam int RESULT_W = 16;
    localparam int FIFO_WORDS = 8;

    // Host pin vector: {buffer sleep, converter sleep, fold, read, select, trigger}.
    localparam int PIN_COUNT = 6;
    localparam int PIN_TRIGGER = 0;
    localparam int PIN_SELECT = 1;
    localparam int PIN_READ = 2;
    localparam int PIN_FOLD = 3;
    localparam int PIN_CONV_SLEEP = 4;
    localparam int PIN_BUF_SLEEP = 5;
    localparam logic [5:0] PIN_IDLE = 6'h37;

    // Conversion timing.
    localparam int APERTURE_NS = 3;
    localparam int CONV_MAX_NS = 180;
    localparam int ACQ_MIN_NS = 70;
    localparam int DATA_VALID_NS = 225;
    localparam int SYNC_CYCLES = 3;
    localparam int APERTURE_CYCLES = (APERTURE_NS / CLK_PERIOD_NS < 1) ? 1 : APERTURE_NS / CLK_PERIOD_NS;
    localparam int CONV_MAX_CYCLES = CONV_MAX_NS / CLK_PERIOD_NS;
    localparam int ACQ_CYCLES = (ACQ_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DATA_VALID_CYCLES = DATA_VALID_NS / CLK_PERIOD_NS;
    localparam int CONV_CYCLES = DATA_VALID_CYCLES - SYNC_CYCLES - APERTURE_CYCLES;

    // Power-down timing.
    localparam int SLEEP_PD_NS = 1500;
    localparam int RESET_RECOVER_NS = 100;
    localparam int WAKE_NS = 5000;
    localparam int REF_SETTLE_MS = 25;
    localparam int SLEEP_PD_CYCLES = (SLEEP_PD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_RECOVER_CYCLES = (RESET_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_CYCLES = WAKE_NS / CLK_PERIOD_NS;
    localparam int REF_SETTLE_CYCLES = REF_SETTLE_MS * 1000000 / CLK_PERIOD_NS;

    typedef enum logic [2:0]
    {
        ST_IDLE = 3'h0,
        ST_CONV = 3'h1,
        ST_ACQ = 3'h3,
        ST_HOLD = 3'h2,
        ST_WAKE = 3'h6
    } conv_state_e;

endpackage

// File: hw/sample_fifo.sv
`timescale 1ns/10ps
module sample_fifo
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
)
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Filling side.
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    // Draining side.
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [CW-1:0] count;
    logic push;
    logic pop;

    // The output register adds one word of slack beyond the memory depth.
    assign in_ready = count < CW'(DEPTH);
    assign push = in_valid && in_ready;
    assign pop = (count != '0) && (!out_valid || out_ready);

    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= AW'(wr_ptr + 1'b1);
            end
            if (pop)
            begin
                rd_ptr <= AW'(rd_ptr + 1'b1);
            end
            count <= CW'(count + CW'(push) - CW'(pop));
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            out_valid <= 1'b0;
            out_data <= '0;
        end
        else if (pop)
        begin
            out_valid <= 1'b1;
            out_data <= mem[rd_ptr];
        end
        else if (out_ready)
        begin
            out_valid <= 1'b0;
        end
    end

endmodule

// File: hw/sar_adc_conversion_readout.sv
`timescale 1ns/10ps
// Operation
// R1 - Trigger fall freezes sample, starts conversion promptly.
// R2 - Internal conversion finishes within 180 ns.
// R3 - At least 70 ns acquisition between conversions.
// R4 - Host keeps trigger widths and 250 ns period.
// R5 - Host keeps inputs quiet around trigger fall.
// R6 - Result valid by 225 ns; busy falls later.
// R7 - Data valid soon after select and read low.
// R8 - Bus released soon after select or read high.
// R9 - Fold change rearranges bus data promptly.
// R10 - Results are two's complement.
// R11 - Short converter sleep pulse resets only.
// R12 - Long converter sleep resets and powers down.
// R13 - Long buffer sleep powers down output buffers.
// R14 - Host never wakes converter with buffers asleep.
// R15 - Converter operational within 5 us of wake.
// R16 - Reference outputs valid within 25 ms.
// R17 - Host waits 25 ms after supply rises.
// R18 - Sleep fall raises busy, releases bus.
// R19 - Host holds other input pulses 10 ns.
// R20 - Busy high only while converting; the code also keeps it high in ST_HOLD and ST_WAKE.
// R21 - Bus driven only with select and read low.
// R22 - Fold puts low byte on upper pins.
// R23 - Host captures result after busy falls.
module sar_adc_conversion_readout
    import adc_pkg::*;
#(
    parameter int RESULT_WIDTH = RESULT_W,
    parameter int FIFO_DEPTH = FIFO_WORDS,
    parameter int REF_SETTLE = REF_SETTLE_CYCLES
)
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Host control pins, asynchronous to clk.
    input wire logic conversion_trigger_n,
    input wire logic chip_select_n,
    input wire logic read_strobe_n,
    input wire logic byte_fold,
    input wire logic converter_sleep_n,
    input wire logic buffer_sleep_n,
    // Host status and data pins.
    output logic busy,
    output logic [RESULT_WIDTH-1:0] data_bus_out,
    output logic data_bus_oe,
    // Analog core.
    input wire logic [RESULT_WIDTH-1:0] raw_code,
    output logic sample_hold,
    output logic converter_powered_down,
    output logic buffers_powered_down,
    output logic reference_output_valid,
    // Result stream.
    output logic [RESULT_WIDTH-1:0] stream_data,
    output logic stream_valid,
    input wire logic stream_ready,
    output logic overrun
);
    localparam int HALF = RESULT_WIDTH / 2;
    localparam int RW = $clog2(REF_SETTLE + 1);
    localparam logic [3:0] CONV_LAST = 4'(CONV_CYCLES - 1);
    localparam logic [3:0] ACQ_LAST = 4'(ACQ_CYCLES - 1);
    localparam logic [7:0] PD_COUNT = 8'(SLEEP_PD_CYCLES);
    localparam logic [7:0] WAKE_COUNT = 8'(WAKE_CYCLES);
    localparam logic [7:0] RECOVER_COUNT = 8'(RESET_RECOVER_CYCLES);

    // Swaps the halves when folding so a byte-wide host reads the low byte on the upper pins.
    function automatic logic [RESULT_WIDTH-1:0] fold_word(input logic [RESULT_WIDTH-1:0] w, input logic fold);
        fold_word = fold ? {w[HALF-1:0], w[RESULT_WIDTH-1:HALF]} : w;
    endfunction

    // The core delivers offset binary; flipping the sign bit gives two's complement.
    function automatic logic [RESULT_WIDTH-1:0] to_twos(input logic [RESULT_WIDTH-1:0] w);
        to_twos = {~w[RESULT_WIDTH-1], w[RESULT_WIDTH-2:0]};
    endfunction

    logic [PIN_COUNT-1:0] pin_meta;
    logic [PIN_COUNT-1:0] pin_sync;
    logic trigger_prev;
    logic trigger_fall;
    logic read_active;
    logic [7:0] low_cnt [2];
    logic [1:0] long_low;
    logic [1:0] sleep_s;
    conv_state_e state;
    conv_state_e next_state;
    logic [3:0] phase_cnt;
    logic [7:0] wake_cnt;
    logic conv_done;
    logic [RESULT_WIDTH-1:0] result;
    logic [RW-1:0] ref_cnt;
    logic push_valid;
    logic fifo_in_ready;

    // Every host pin passes two flops before any logic looks at it.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pin_meta <= PIN_IDLE;
            pin_sync <= PIN_IDLE;
        end
        else
        begin
            pin_meta <= {buffer_sleep_n, converter_sleep_n, byte_fold, read_strobe_n, chip_select_n,
                         conversion_trigger_n};
            pin_sync <= pin_meta;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            trigger_prev <= 1'b1;
        end
        else
        begin
            trigger_prev <= pin_sync[PIN_TRIGGER];
        end
    end

    assign trigger_fall = trigger_prev && !pin_sync[PIN_TRIGGER];
    assign sleep_s = {pin_sync[PIN_BUF_SLEEP], pin_sync[PIN_CONV_SLEEP]};
    assign read_active = !pin_sync[PIN_SELECT] && !pin_sync[PIN_READ] && sleep_s[0];

    // Low-time meters for both sleep inputs; a pulse shorter than the limit never powers down.
    for (genvar g = 0; g < 2; g++)
    begin : g_sleep_meter
        always_ff @(posedge clk)
        begin
            if (rst || sleep_s[g])
            begin
                low_cnt[g] <= 8'h00;
            end
            else if (low_cnt[g] != PD_COUNT)
            begin
                low_cnt[g] <= 8'(low_cnt[g] + 8'h01);
            end
        end
        assign long_low[g] = (low_cnt[g] == PD_COUNT); // [R12] [R13]
    end

    always_comb
    begin
        next_state = state;
        case (state)
            ST_IDLE:
            begin
                if (trigger_fall && fifo_in_ready)
                begin
                    next_state = ST_CONV; // [R1]
                end
            end
            ST_CONV:
            begin
                if (phase_cnt == CONV_LAST)
                begin
                    next_state = ST_ACQ; // [R2]
                end
            end
            ST_ACQ:
            begin
                if (phase_cnt == ACQ_LAST)
                begin
                    next_state = ST_IDLE; // [R3]
                end
            end
            ST_HOLD:
            begin
                if (sleep_s[0])
                begin
                    next_state = ST_WAKE;
                end
            end
            ST_WAKE:
            begin
                if (wake_cnt == 8'h00 && reference_output_valid)
                begin
                    next_state = ST_ACQ; // [R15] [R16]
                end
            end
            default:
            begin
                next_state = ST_HOLD;
            end
        endcase
        if (!sleep_s[0])
        begin
            next_state = ST_HOLD; // [R11]
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state <= ST_WAKE;
            phase_cnt <= 4'h0;
        end
        else
        begin
            state <= next_state;
            phase_cnt <= (next_state != state) ? 4'h0 : 4'(phase_cnt + 4'h1);
        end
    end

    // Recovery length is chosen while the input is still low, so a long pulse needs the full wake time.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wake_cnt <= 8'h00;
        end
        else if (state == ST_HOLD)
        begin
            wake_cnt <= (long_low[0] || converter_powered_down) ? WAKE_COUNT : RECOVER_COUNT; // [R15]
        end
        else if (state == ST_WAKE && wake_cnt != 8'h00)
        begin
            wake_cnt <= 8'(wake_cnt - 8'h01);
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            converter_powered_down <= 1'b0;
        end
        else if (long_low[0])
        begin
            converter_powered_down <= 1'b1; // [R12]
        end
        else if (state == ST_WAKE && next_state == ST_ACQ)
        begin
            converter_powered_down <= 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            buffers_powered_down <= 1'b0;
        end
        else if (long_low[1])
        begin
            buffers_powered_down <= 1'b1; // [R13]
        end
        else if (sleep_s[1])
        begin
            buffers_powered_down <= 1'b0;
        end
    end

    // The reference settles from reset and again after every buffer power-down.
    always_ff @(posedge clk)
    begin
        if (rst || buffers_powered_down || !sleep_s[1])
        begin
            ref_cnt <= '0;
        end
        else if (ref_cnt != RW'(REF_SETTLE))
        begin
            ref_cnt <= RW'(ref_cnt + 1'b1);
        end
    end

    assign reference_output_valid = (ref_cnt == RW'(REF_SETTLE)); // [R16]

    assign conv_done = (state == ST_CONV) && (phase_cnt == CONV_LAST);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            sample_hold <= 1'b0;
        end
        else
        begin
            sample_hold <= (next_state == ST_CONV); // [R1]
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            result <= '0;
            push_valid <= 1'b0;
        end
        else
        begin
            push_valid <= conv_done;
            if (conv_done)
            begin
                result <= to_twos(raw_code); // [R10]
            end
        end
    end

    // Bus data load in the same edge as the result so busy, which lags a cycle, falls after it.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            data_bus_out <= '0;
        end
        else if (conv_done)
        begin
            data_bus_out <= fold_word(to_twos(raw_code), pin_sync[PIN_FOLD]); // [R6] [R22]
        end
        else
        begin
            data_bus_out <= fold_word(result, pin_sync[PIN_FOLD]); // [R9]
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            data_bus_oe <= 1'b0;
        end
        else
        begin
            data_bus_oe <= read_active; // [R7] [R8] [R21] [R18]
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            busy <= 1'b1;
        end
        else
        begin
            busy <= (state == ST_CONV) || (state == ST_HOLD) || (state == ST_WAKE) || !sleep_s[0]; // [R20] [R18]
        end
    end

    // A trigger that finds the buffer full is dropped and flagged rather than overwriting a word.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            overrun <= 1'b0;
        end
        else
        begin
            overrun <= (state == ST_IDLE) && trigger_fall && !fifo_in_ready && sleep_s[0];
        end
    end

    sample_fifo #(
        .WIDTH(RESULT_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_result_fifo (
        .clk(clk),
        .rst(rst),
        .in_data(result),
        .in_valid(push_valid),
        .in_ready(fifo_in_ready),
        .out_data(stream_data),
        .out_valid(stream_valid),
        .out_ready(stream_ready)
    );

    a_freeze_on_trigger: assert property (@(posedge clk) disable iff (rst) // [R1]
        (state == ST_IDLE && trigger_fall && fifo_in_ready && sleep_s[0]) |=> sample_hold)
        else $error("Sample not frozen after accepted trigger.");

    a_conv_bound: assert property (@(posedge clk) disable iff (rst) // [R2]
        $rose(sample_hold) |-> ##[1:9] !sample_hold)
        else $error("Conversion longer than allowed.");

    a_acq_gap: assert property (@(posedge clk) disable iff (rst) // [R3]
        $fell(sample_hold) |-> !sample_hold[*4])
        else $error("Acquisition interval too short.");

    a_result_latency: assert property (@(posedge clk) disable iff (rst) // [R6]
        (state == ST_IDLE && next_state == ST_CONV) |-> ##8 (state != ST_CONV && state != ST_IDLE))
        else $error("Result not ready in time after trigger.");

    a_busy_after_data: assert property (@(posedge clk) disable iff (rst) // [R6]
        $fell(busy) |-> (state == ST_ACQ && $past(state) == ST_ACQ))
        else $error("Busy fell before data was valid.");

    a_twos_result: assert property (@(posedge clk) disable iff (rst) // [R10]
        conv_done |=> result == {~$past(raw_code[RESULT_WIDTH-1]), $past(raw_code[RESULT_WIDTH-2:0])})
        else $error("Result not in two's complement.");

    a_bus_enable: assert property (@(posedge clk) disable iff (rst) // [R21]
        data_bus_oe |-> (!$past(pin_meta[PIN_SELECT], 2) && !$past(pin_meta[PIN_READ], 2)))
        else $error("Bus driven without select and read.");

    a_fold_layout: assert property (@(posedge clk) disable iff (rst) // [R22]
        (state == ST_IDLE && $past(state) == ST_IDLE) |->
            ($past(pin_sync[PIN_FOLD]) ? (data_bus_out[RESULT_WIDTH-1:HALF] == result[HALF-1:0])
            : (data_bus_out == result)))
        else $error("Bus layout does not match fold select.");

    a_sleep_busy: assert property (@(posedge clk) disable iff (rst) // [R18]
        $fell(sleep_s[0]) |=> (busy && !data_bus_oe))
        else $error("Busy or bus wrong after converter sleep.");

    a_long_sleep: assert property (@(posedge clk) disable iff (rst) // [R12]
        (!sleep_s[0] && low_cnt[0] == PD_COUNT - 8'h01) |-> ##2 converter_powered_down)
        else $error("Converter not powered down after long sleep.");

    a_buffer_sleep: assert property (@(posedge clk) disable iff (rst) // [R13]
        (!sleep_s[1] && low_cnt[1] == PD_COUNT - 8'h01) |-> ##2 buffers_powered_down)
        else $error("Buffers not powered down after long sleep.");

    a_wake_time: assert property (@(posedge clk) disable iff (rst) // [R15]
        ($rose(sleep_s[0]) && reference_output_valid && sleep_s[1]) |-> ##[1:255] (state != ST_WAKE))
        else $error("Converter not operational in time after wake.");

endmodule

// File: verif/adc_host_model.sv
`timescale 1ns/10ps
module adc_host_model
    import adc_pkg::*;
(
    // Clock and bus from the device.
    input wire logic clk,
    input wire logic [RESULT_W-1:0] data_bus_out,
    input wire logic data_bus_oe,
    // Control pins towards the device.
    output logic conversion_trigger_n,
    output logic chip_select_n,
    output logic read_strobe_n,
    output logic byte_fold,
    output logic converter_sleep_n,
    output logic buffer_sleep_n,
    // Bus level as the host sees it.
    output logic [RESULT_W-1:0] bus_seen
);
    logic [RESULT_W-1:0] last_bus = '0;

    // A released bus shows the inverse of its last value, so stale data never passes for valid data.
    assign bus_seen = data_bus_oe ? data_bus_out : ~last_bus;

    always @(posedge clk)
        if (data_bus_oe)
            last_bus <= data_bus_out;

    initial
    begin
        {buffer_sleep_n, converter_sleep_n, byte_fold, read_strobe_n, chip_select_n, conversion_trigger_n} = PIN_IDLE;
    end

    // Only the trigger moves here, the other pins stay quiet around its fall.
    task automatic trigger(input int low_cycles);
        @(negedge clk);
        conversion_trigger_n = 1'b0;
        repeat (low_cycles) @(negedge clk);
        conversion_trigger_n = 1'b1;
    endtask

    task automatic set_read(input logic cs, input logic rd, input logic fold);
        @(negedge clk);
        chip_select_n = !cs;
        read_strobe_n = !rd;
        byte_fold = fold;
    endtask

    task automatic sleep_enter(input logic buffers);
        @(negedge clk);
        converter_sleep_n = 1'b0;
        buffer_sleep_n = !buffers;
    endtask

    // Buffers wake first so the reserved pin combination never appears.
    task automatic sleep_leave();
        @(negedge clk);
        buffer_sleep_n = 1'b1;
        @(negedge clk);
        converter_sleep_n = 1'b1;
    endtask
endmodule

// File: verif/sar_adc_conversion_readout_tb.sv
`timescale 1ns/10ps
`define CHECK(got, exp) \
    begin \
        n_tests++; \
        if ((got) !== (exp)) \
        begin \
            n_errors++; \
            $display("[ERR] %0t mismatch got %h expected %h", $time, (got), (exp)); \
        end \
    end
module sar_adc_conversion_readout_tb;
    import adc_pkg::*;
    localparam int SETTLE = 20;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [RESULT_W-1:0] raw_code = '0;
    logic stream_ready = 1'b1;
    logic trig_n, cs_n, rd_n, fold, conv_sleep_n, buf_sleep_n;
    logic busy, oe, sample_hold, conv_pd, buf_pd, ref_valid, stream_valid, overrun;
    logic [RESULT_W-1:0] bus, stream_data, bus_seen;
    logic [RESULT_W-1:0] words[$];
    int n_errors = 0;
    int n_tests = 0;

    always #(CLK_PERIOD_NS / 2) clk = ~clk;

    sar_adc_conversion_readout #(.REF_SETTLE(SETTLE)) dut
    (
        .clk(clk), .rst(rst), .conversion_trigger_n(trig_n), .chip_select_n(cs_n),
        .read_strobe_n(rd_n), .byte_fold(fold), .converter_sleep_n(conv_sleep_n),
        .buffer_sleep_n(buf_sleep_n), .busy(busy), .data_bus_out(bus), .data_bus_oe(oe),
        .raw_code(raw_code), .sample_hold(sample_hold), .converter_powered_down(conv_pd),
        .buffers_powered_down(buf_pd), .reference_output_valid(ref_valid),
        .stream_data(stream_data), .stream_valid(stream_valid), .stream_ready(stream_ready),
        .overrun(overrun)
    );

    adc_host_model host
    (
        .clk(clk), .data_bus_out(bus), .data_bus_oe(oe), .conversion_trigger_n(trig_n),
        .chip_select_n(cs_n), .read_strobe_n(rd_n), .byte_fold(fold),
        .converter_sleep_n(conv_sleep_n), .buffer_sleep_n(buf_sleep_n), .bus_seen(bus_seen)
    );

    always @(posedge clk)
        if (!rst && stream_valid && stream_ready)
            words.push_back(stream_data);

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic wait_idle(input int limit);
        int t;
        t = 0;
        while (busy !== 1'b0 && t < limit)
        begin
            @(negedge clk);
            t++;
        end
        `CHECK(busy, 1'b0)
    endtask

    task automatic expect_word(input logic [RESULT_W-1:0] exp);
        logic [RESULT_W-1:0] w;
        w = (words.size() > 0) ? words.pop_front() : 'x;
        `CHECK(w, exp)
    endtask

    // Counts cycles from the trigger fall; busy must drop inside the data-valid budget.
    task automatic convert(input logic [RESULT_W-1:0] code);
        int t;
        @(negedge clk);
        raw_code = code;
        host.trigger(1);
        t = 1;
        while (sample_hold !== 1'b1 && t < 6)
        begin
            @(negedge clk);
            t++;
        end
        `CHECK(sample_hold, 1'b1)
        @(negedge clk);
        t++;
        `CHECK(busy, 1'b1)
        while (busy !== 1'b0 && t < 20)
        begin
            @(negedge clk);
            t++;
        end
        `CHECK(t <= DATA_VALID_CYCLES, 1'b1)
        `CHECK(sample_hold, 1'b0)
        repeat (3) @(negedge clk);
    endtask

    task automatic t_codes();
        logic [RESULT_W-1:0] codes[5] = '{16'h0000, 16'h7fff, 16'h8000, 16'hffff, 16'h1234};
        foreach (codes[i])
        begin
            convert(codes[i]);
            expect_word(codes[i] ^ 16'h8000);
        end
    endtask

    task automatic t_read();
        convert(16'h3c5a);
        expect_word(16'hbc5a);
        host.set_read(1'b1, 1'b0, 1'b0);
        repeat (4) @(negedge clk);
        `CHECK(oe, 1'b0)
        host.set_read(1'b1, 1'b1, 1'b0);
        repeat (3) @(negedge clk);
        `CHECK(bus_seen, 16'hbc5a)
        host.set_read(1'b1, 1'b1, 1'b1);
        repeat (3) @(negedge clk);
        `CHECK(bus_seen, 16'h5abc)
        host.set_read(1'b0, 1'b0, 1'b0);
        repeat (3) @(negedge clk);
        `CHECK(oe, 1'b0)
        host.set_read(1'b1, 1'b1, 1'b0);
        convert(16'h0080);
        `CHECK(bus_seen, 16'h8080)
        expect_word(16'h8080);
        host.set_read(1'b0, 1'b0, 1'b0);
    endtask

    // A second fall inside a running conversion must not start another one.
    task automatic t_refuse();
        @(negedge clk);
        raw_code = 16'h0f0f;
        host.trigger(1);
        repeat (2) @(negedge clk);
        host.trigger(1);
        repeat (20) @(negedge clk);
        `CHECK(words.size(), 1)
        expect_word(16'h8f0f);
    endtask

    task automatic t_fifo();
        int k;
        logic ov;
        stream_ready = 1'b0;
        for (k = 0; k < 9; k++)
            convert({12'h800, k[3:0]});
        @(negedge clk);
        raw_code = '0;
        host.trigger(1);
        ov = 1'b0;
        repeat (6)
        begin
            @(negedge clk);
            ov = ov | overrun;
        end
        `CHECK(ov, 1'b1)
        `CHECK(busy, 1'b0)
        repeat (24)
        begin
            @(negedge clk);
            stream_ready = ~stream_ready;
        end
        stream_ready = 1'b1;
        repeat (4) @(negedge clk);
        `CHECK(words.size(), 9)
        for (k = 0; k < 9; k++)
            expect_word({12'h000, k[3:0]});
    endtask

    task automatic t_sleep_short();
        host.set_read(1'b1, 1'b1, 1'b0);
        repeat (3) @(negedge clk);
        `CHECK(oe, 1'b1)
        host.sleep_enter(1'b0);
        repeat (3) @(negedge clk);
        `CHECK(busy, 1'b1)
        `CHECK(oe, 1'b0)
        `CHECK(conv_pd, 1'b0)
        host.sleep_leave();
        host.set_read(1'b0, 1'b0, 1'b0);
        wait_idle(60);
        convert(16'h0001);
        expect_word(16'h8001);
    endtask

    task automatic t_sleep_long(input logic buffers);
        host.sleep_enter(buffers);
        repeat (80) @(negedge clk);
        `CHECK(conv_pd, 1'b1)
        `CHECK(buf_pd, buffers)
        `CHECK(ref_valid, !buffers)
        host.sleep_leave();
        wait_idle(buffers ? SETTLE + 270 : 262);
        `CHECK(conv_pd, 1'b0)
        `CHECK(buf_pd, 1'b0)
        `CHECK(ref_valid, 1'b1)
        convert(16'h7ffe);
        expect_word(16'hfffe);
    endtask

    initial
    begin
        #(CLK_PERIOD_NS * 5000);
        n_errors++;
        summarize();
    end

    initial
    begin
        repeat (12) @(negedge clk);
        `CHECK(oe, 1'b0)
        rst = 1'b0;
        wait_idle(SETTLE + 40);
        t_codes();
        t_read();
        t_refuse();
        t_fifo();
        t_sleep_short();
        t_sleep_long(1'b0);
        t_sleep_long(1'b1);
        summarize();
    end
endmodule
